/* File: hw/clock_switch_pkg.sv */
// Purpose: shared constants and types for the glitch-free clock selector.
// Assumes: one 200 MHz sampling clock; both source clocks well below half of it.
// Notes: all stage counts are in edges of the sampled source clocks.
package clock_switch_pkg;

  // sampling clock
  localparam int CLOCK_PERIOD_PS = 5000;  // 200 MHz
  localparam int SYNC_STAGES = 2;  // flip-flops in every pin synchroniser

  // fanout
  localparam int COPY_COUNT = 8;  // identical output copies

  // pins gathered into one synchroniser, bit positions
  localparam int PIN_CLOCK_A = 0;
  localparam int PIN_CLOCK_B = 1;
  localparam int PIN_SELECT = 2;
  localparam int PIN_SELECT_OPEN = 3;
  localparam int PIN_LOSS_A = 4;
  localparam int PIN_LOSS_B = 5;
  localparam int PIN_POR_CHARGED = 6;
  localparam int PIN_RUNT_OFF = 7;
  localparam int PIN_COUNT = 8;

  // switchover stage counts
  localparam logic [2:0] STUCK_PULSES = 3'h4;  // new-clock rises before old is deemed stuck
  localparam logic [2:0] LOW_EDGES = 3'h2;  // new-clock falls spent holding low
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // switchover stages, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,  // tracking the current clock
    ST_OLD = 3'h2,  // finishing the old clock's pulse
    ST_LOW = 3'h4   // parked low, waiting on the new clock
  } state_t;

endpackage

/* File: hw/pin_sync.sv */
// Purpose: two flip-flop synchroniser for a group of asynchronous pins.
// Assumes: each bit is independent; no bus coherency is implied.
// Notes: first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = clock_switch_pkg::PIN_COUNT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] meta_q;  // may go metastable, read only below

  // two stages give the metastable first stage a full period to settle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      pins_sync <= '0;
    end else begin
      meta_q <= pins;
      pins_sync <= meta_q;
    end
  end

endmodule

/* File: hw/clock_fanout.sv */
// Purpose: drive eight registered copies of the chosen clock level.
// Assumes: level is already glitch-free at the sampling clock.
// Notes: one flop per copy keeps the copies aligned to the same edge.
`timescale 1ns/1ps
module clock_fanout (
  input wire logic clock,
  input wire logic resetn,
  input wire logic level,
  output logic [clock_switch_pkg::COPY_COUNT-1:0] copies_q
);

  // every copy is its own flop so loads are split between drivers
  for (genvar i = 0; i < clock_switch_pkg::COPY_COUNT; i++) begin : g_copy
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        copies_q[i] <= 1'b0;
      end else begin
        copies_q[i] <= level;
      end
    end
  end

endmodule

/* File: hw/clock_switch.sv */
// Purpose: two-input clock selector with fanout; with runt suppression on, a switchover never emits a shortened phase.
// Assumes: source clocks are sampled at 200 MHz; pins are asynchronous to clock.
// Notes: the stage counts are small fixed edge counts; the synchroniser delay
// makes the exact number of edges per stage vary, which is harmless.
`timescale 1ns/1ps

module clock_switch (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_in_a,  // first source clock
  input wire logic clock_in_b,  // second source clock
  input wire logic select_pin,  // 0 picks a, 1 picks b
  input wire logic select_open,  // high while nothing drives the select pin
  input wire logic signal_loss_a,  // input a swing below the usable limit
  input wire logic signal_loss_b,  // input b swing below the usable limit
  input wire logic power_on_reset_pin,  // high once the reset capacitor has charged
  input wire logic runt_suppression_off,  // strap: reset pin tied to the supply
  output logic [clock_switch_pkg::COPY_COUNT-1:0] clock_out_copies
);

  // synchronised pin group
  logic [clock_switch_pkg::PIN_COUNT-1:0] pins;
  logic [clock_switch_pkg::PIN_COUNT-1:0] pins_s;

  // per-input view, index 0 is a, 1 is b
  logic [1:0] raw_s;  // synced clock levels
  logic [1:0] loss_s;  // synced loss indicators
  logic [1:0] lvl;  // level after the loss hold
  logic [1:0] hold_q;  // last valid level, also the previous sample
  logic [1:0] rise;  // rising edge of lvl
  logic [1:0] fall;  // falling edge of lvl

  // control
  logic sel_eff;  // select after the open-pin default
  logic por_active;  // capacitor still charging
  logic bypass;  // runt suppression switched off
  logic ok;  // switchover logic free to run

  // switchover state
  clock_switch_pkg::state_t state_q;
  clock_switch_pkg::state_t state_d;
  logic cur_q;  // input now driving the outputs
  logic cur_d;
  logic [2:0] cnt_q;  // edges counted in the present stage
  logic [2:0] cnt_d;

  // selected levels and edges
  logic lvl_cur;
  logic lvl_sel;
  logic fall_cur;
  logic rise_new;
  logic fall_new;
  logic out_d;  // level sent to the fanout

  assign pins[clock_switch_pkg::PIN_CLOCK_A] = clock_in_a;
  assign pins[clock_switch_pkg::PIN_CLOCK_B] = clock_in_b;
  assign pins[clock_switch_pkg::PIN_SELECT] = select_pin;
  assign pins[clock_switch_pkg::PIN_SELECT_OPEN] = select_open;
  assign pins[clock_switch_pkg::PIN_LOSS_A] = signal_loss_a;
  assign pins[clock_switch_pkg::PIN_LOSS_B] = signal_loss_b;
  assign pins[clock_switch_pkg::PIN_POR_CHARGED] = power_on_reset_pin;
  assign pins[clock_switch_pkg::PIN_RUNT_OFF] = runt_suppression_off;

  // every pin, select included, crosses through two flops before use
  pin_sync #(
    .WIDTH(clock_switch_pkg::PIN_COUNT)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pins(pins),
    .pins_sync(pins_s)
  );

  assign raw_s[0] = pins_s[clock_switch_pkg::PIN_CLOCK_A];
  assign raw_s[1] = pins_s[clock_switch_pkg::PIN_CLOCK_B];
  assign loss_s[0] = pins_s[clock_switch_pkg::PIN_LOSS_A];
  assign loss_s[1] = pins_s[clock_switch_pkg::PIN_LOSS_B];

  // an open select pin is pulled high, so input b wins by default
  assign sel_eff = pins_s[clock_switch_pkg::PIN_SELECT_OPEN] |
                   pins_s[clock_switch_pkg::PIN_SELECT];
  assign por_active = ~pins_s[clock_switch_pkg::PIN_POR_CHARGED];
  assign bypass = pins_s[clock_switch_pkg::PIN_RUNT_OFF];
  assign ok = ~por_active & ~bypass;

  // both inputs get the same loss hold and edge detect, so the
  // switchover behaves the same whichever input is primary
  for (genvar i = 0; i < 2; i++) begin : g_input
    // a lost input freezes at its last valid level instead of chattering
    assign lvl[i] = loss_s[i] ? hold_q[i] : raw_s[i];
    assign rise[i] = lvl[i] & ~hold_q[i];
    assign fall[i] = ~lvl[i] & hold_q[i];

    // remember the last valid level
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        hold_q[i] <= 1'b0;
      end else begin
        hold_q[i] <= lvl[i];
      end
    end
  end

  // current, new and directly selected views
  assign lvl_cur = lvl[cur_q];
  assign lvl_sel = lvl[sel_eff];
  assign fall_cur = fall[cur_q];
  assign rise_new = rise[~cur_q];
  assign fall_new = fall[~cur_q];

  // next-state logic for the switchover sequence
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    if (por_active) begin
      // reset parks the logic on whatever select asks for
      state_d = clock_switch_pkg::ST_RUN;
      cur_d = sel_eff;
      cnt_d = clock_switch_pkg::COUNT_RESET;
    end else if (bypass) begin
      // no suppression: follow select at once
      state_d = clock_switch_pkg::ST_RUN;
      cur_d = sel_eff;
      cnt_d = clock_switch_pkg::COUNT_RESET;
    end else begin
      case (state_q)
        clock_switch_pkg::ST_RUN: begin
          // a change of select opens the sequence
          if (sel_eff != cur_q) begin
            state_d = clock_switch_pkg::ST_OLD;
            cnt_d = clock_switch_pkg::COUNT_RESET;
          end
        end
        clock_switch_pkg::ST_OLD: begin
          if (fall_cur) begin
            // the old pulse has finished cleanly, park low
            state_d = clock_switch_pkg::ST_LOW;
            cnt_d = clock_switch_pkg::COUNT_RESET;
          end else if (rise_new) begin
            // old clock stuck: give up after a few new pulses, whatever
            // level it is stuck at; the 1.5:1 ratio keeps this from firing
            // on a healthy old clock
            if (cnt_q == clock_switch_pkg::STUCK_PULSES - 3'h1) begin
              state_d = clock_switch_pkg::ST_LOW;
              cnt_d = clock_switch_pkg::COUNT_RESET;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        clock_switch_pkg::ST_LOW: begin
          // only leave on a new-clock fall so the first tracked phase
          // is a whole low phase
          if (fall_new) begin
            if (cnt_q == clock_switch_pkg::LOW_EDGES - 3'h1) begin
              state_d = clock_switch_pkg::ST_RUN;
              cur_d = ~cur_q;
              cnt_d = clock_switch_pkg::COUNT_RESET;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        default: begin
          // illegal code: recover to tracking
          state_d = clock_switch_pkg::ST_RUN;
          cnt_d = clock_switch_pkg::COUNT_RESET;
        end
      endcase
    end
  end

  // stage register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= clock_switch_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // current input register; b matches the open-select default
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_q <= 1'b1;
    end else begin
      cur_q <= cur_d;
    end
  end

  // stage edge counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= clock_switch_pkg::COUNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // output level per stage
  always_comb begin
    if (por_active) begin
      out_d = 1'b0;  // quiet until the logic is known
    end else if (bypass) begin
      out_d = lvl_sel;
    end else begin
      case (state_q)
        clock_switch_pkg::ST_RUN: out_d = lvl_cur;
        clock_switch_pkg::ST_OLD: out_d = lvl_cur;
        clock_switch_pkg::ST_LOW: out_d = 1'b0;
        default: out_d = 1'b0;
      endcase
    end
  end

  // registered fanout of the chosen level
  clock_fanout u_fanout (
    .clock(clock),
    .resetn(resetn),
    .level(out_d),
    .copies_q(clock_out_copies)
  );

  // checks on the switchover and the fanout
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_run_ok;
    ok && state_q == clock_switch_pkg::ST_RUN;
  endsequence

  sequence s_low_exit;
    ok && state_q == clock_switch_pkg::ST_LOW && fall_new &&
      cnt_q == clock_switch_pkg::LOW_EDGES - 3'h1;
  endsequence

  sequence s_lost_run;
    ok && state_q == clock_switch_pkg::ST_RUN && loss_s[cur_q] && sel_eff == cur_q;
  endsequence

  a_copies_equal: assert property (
    clock_out_copies == '0 || clock_out_copies == '1)
    else $error("output copies differ");

  a_run_tracks: assert property (
    s_run_ok |=> clock_out_copies[0] == $past(lvl_cur))
    else $error("output not tracking current clock");

  a_bypass_direct: assert property (
    (bypass && !por_active) |=> clock_out_copies[0] == $past(lvl_sel))
    else $error("bypass output not following selected input");

  a_por_state: assert property (
    por_active |=> state_q == clock_switch_pkg::ST_RUN && cur_q == $past(sel_eff))
    else $error("reset did not park on the selected input");

  a_open_default: assert property (
    (por_active && pins_s[clock_switch_pkg::PIN_SELECT_OPEN]) |=> cur_q)
    else $error("open select did not pick input b");

  a_switch_start: assert property (
    (s_run_ok and sel_eff != cur_q) |=> state_q == clock_switch_pkg::ST_OLD)
    else $error("select change did not open the switchover");

  a_old_follows: assert property (
    (ok && state_q == clock_switch_pkg::ST_OLD) |=>
      clock_out_copies[0] == $past(lvl_cur))
    else $error("stage one not following old clock");

  a_low_holds: assert property (
    (ok && state_q == clock_switch_pkg::ST_LOW) |=> clock_out_copies == '0)
    else $error("stage two output not low");

  a_stage_exit: assert property (
    s_low_exit |=> state_q == clock_switch_pkg::ST_RUN && cur_q != $past(cur_q) &&
      clock_out_copies == '0)
    else $error("stage three did not start cleanly on the new clock");

  a_stuck_bound: assert property (
    (ok && state_q == clock_switch_pkg::ST_OLD && rise_new && !fall_cur &&
      cnt_q == clock_switch_pkg::STUCK_PULSES - 3'h1) |=>
      state_q == clock_switch_pkg::ST_LOW)
    else $error("stuck old clock not abandoned");

  a_loss_hold: assert property (
    s_lost_run [*2] |=> $stable(clock_out_copies))
    else $error("lost input still toggles the output");

endmodule

/* File: tb/source_clocks.sv */
// Purpose: behavioural pair of source clocks facing the selector.
// Assumes: half periods are counted in sampling clock cycles.
// Notes: a stopped source holds a chosen level; a lost one shows noise.
`timescale 1ns/1ps
module source_clocks (
  input wire logic clock,
  input wire logic [1:0][3:0] half,  // half period per source, index 1 is b
  input wire logic [1:0] run,  // source toggles while high
  input wire logic [1:0] stuck,  // level held while stopped
  input wire logic [1:0] lost,  // amplitude gone
  output logic clock_in_a,
  output logic clock_in_b
);
  logic [1:0] level;  // true oscillator levels
  logic [1:0][3:0] count;  // cycles spent in the current phase
  logic noise;  // changes every cycle so a lost pin never looks stable
  initial begin
    level = 2'h0;
    count = '0;
    noise = 1'b0;
  end
  // toggle on the falling edge, away from the selector's sampling edge;
  // callers keep the two half periods within 1.5:1 of each other
  always @(negedge clock) begin
    noise = ~noise;
    for (int i = 0; i < 2; i++) begin
      if (!run[i]) begin
        level[i] = stuck[i];
        count[i] = 4'h0;
      end else if (count[i] + 4'h1 >= half[i]) begin
        level[i] = ~level[i];
        count[i] = 4'h0;
      end else begin
        count[i] = count[i] + 4'h1;
      end
    end
  end
  assign clock_in_a = lost[0] ? noise : level[0];
  assign clock_in_b = lost[1] ? noise : level[1];
endmodule

/* File: tb/glitchless_clock_switch_fanout_bench.sv */
// Purpose: self-checking bench for the glitch-free selector with fanout.
// Assumes: sources are 8 to 10 sampling cycles per period.
// Notes: outputs show a pin level 3 edges later, so tracking reads bit 2 of the pin history.
`timescale 1ns/1ps
module glitchless_clock_switch_fanout_bench;
  typedef struct packed {logic sel; logic open; logic a; logic b; logic want;} row_t;
  logic clock, resetn, select_pin, select_open, signal_loss_a, signal_loss_b;
  logic power_on_reset_pin, runt_suppression_off, clock_in_a, clock_in_b;
  logic [1:0][3:0] half;  // source half periods
  logic [1:0] run, stuck;  // source controls
  logic [7:0] clock_out_copies, hold;
  logic track_on, track_b, phase_on, last_level;  // monitor controls
  logic [2:0] hist_a, hist_b;  // pin history, newest in bit 0
  int n_errors, n_compared, cycles, run_len, min_phase, max_low, max_high;
  // bypass cases: static levels, select and floating select
  row_t rows [6] = '{5'h05, 5'h02, 5'h13, 5'h14, 5'h0B, 5'h0C};

  clock_switch clock_switch_i (.clock(clock), .resetn(resetn), .clock_in_a(clock_in_a),
    .clock_in_b(clock_in_b), .select_pin(select_pin), .select_open(select_open),
    .signal_loss_a(signal_loss_a), .signal_loss_b(signal_loss_b),
    .power_on_reset_pin(power_on_reset_pin), .runt_suppression_off(runt_suppression_off),
    .clock_out_copies(clock_out_copies));
  source_clocks source_clocks_i (.clock(clock), .half(half), .run(run), .stuck(stuck),
    .lost({signal_loss_b, signal_loss_a}), .clock_in_a(clock_in_a), .clock_in_b(clock_in_b));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // move select, keep following the old clock briefly, then demand the new one
  task automatic switch_to(input logic to_b);
    @(negedge clock);
    select_pin = to_b;
    max_low = 0;
    repeat (3) @(negedge clock);  // still tracking the old clock here
    track_on = 1'b0;
    repeat (60) @(negedge clock);
    check("low_hold", max_low >= 2 * half[to_b], 1'b1);
    track_b = to_b;
    track_on = 1'b1;
    repeat (40) @(negedge clock);
  endtask

  // per-cycle monitor: timeout, tracking, identical copies, phase lengths
  always @(posedge clock) begin
    cycles++;
    if (track_on) begin
      check("follow", clock_out_copies, {8{track_b ? hist_b[2] : hist_a[2]}});
    end else begin
      check("copies", clock_out_copies, {8{clock_out_copies[0]}});
    end
    if (clock_out_copies[0] === last_level) begin
      run_len++;
    end else begin
      if (phase_on) check("phase", run_len >= min_phase, 1'b1);
      if (last_level && run_len > max_high) max_high = run_len;
      if (!last_level && run_len > max_low) max_low = run_len;
      run_len = 1;
      last_level = clock_out_copies[0];
    end
    hist_a = {hist_a[1:0], clock_in_a};
    hist_b = {hist_b[1:0], clock_in_b};
    // the ceiling sits far above the planned run, so reaching it means a hang
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    {resetn, select_pin, select_open, signal_loss_a, signal_loss_b} = 5'h00;
    {power_on_reset_pin, runt_suppression_off, track_on, track_b, phase_on} = 5'h18;
    {last_level, hist_a, hist_b, run, stuck} = '0;
    half = {4'h5, 4'h4};  // ratio 1.25
    {n_errors, n_compared, cycles, run_len, max_low, max_high} = '0;
    min_phase = 4;
    repeat (12) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    // plain multiplexer with static source levels
    foreach (rows[i]) begin
      @(negedge clock);
      {select_pin, select_open, stuck[0], stuck[1]} = rows[i][4:1];
      repeat (6) @(negedge clock);
      check("bypass", clock_out_copies, {8{rows[i].want}});
    end
    // second reset, capacitor still charging, select low, sources running
    {resetn, power_on_reset_pin, runt_suppression_off, select_pin, select_open} = 5'h00;
    run = 2'h3;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    repeat (20) @(negedge clock) check("por_low", clock_out_copies, 8'h00);
    power_on_reset_pin = 1'b1;
    repeat (12) @(negedge clock);
    track_on = 1'b1;  // input a chosen straight out of reset
    phase_on = 1'b1;
    repeat (40) @(negedge clock);
    switch_to(1'b1);
    switch_to(1'b0);
    // old clock stuck high, then switch to b; stop it just after a rise so
    // its last high phase is stretched, never cut short by the source
    stuck[0] = 1'b1;
    @(posedge clock_in_a);
    run[0] = 1'b0;
    max_high = 0;
    repeat (10) @(negedge clock);
    switch_to(1'b1);
    check("high_hold", max_high >= 6 * half[1] + 8, 1'b1);
    run[0] = 1'b1;
    // old clock stuck low, then switch to a
    stuck[1] = 1'b0;
    @(negedge clock_in_b);
    run[1] = 1'b0;
    repeat (10) @(negedge clock);
    switch_to(1'b0);
    run[1] = 1'b1;
    // selected input loses amplitude: output must freeze
    phase_on = 1'b0;
    track_on = 1'b0;
    signal_loss_a = 1'b1;
    repeat (4) @(negedge clock);
    hold = clock_out_copies;
    repeat (30) @(negedge clock) check("loss_hold", clock_out_copies, hold);
    signal_loss_a = 1'b0;
    repeat (6) @(negedge clock);
    track_on = 1'b1;
    repeat (20) @(negedge clock);
    close_out();
  end
endmodule
